//--- inc/dtp_defs.svh
// constants for the drive telegram parameter/process interpreter
// assumes inclusion by bare name from package and design files
`ifndef DTP_DEFS_SVH
`define DTP_DEFS_SVH

// parameter key word fields
`define DTP_CMD_MSB 15
`define DTP_CMD_LSB 12
`define DTP_PNUM_MSB 10
`define DTP_PNUM_LSB 0
`define DTP_PNUM_W 11

// command codes, master to slave
`define DTP_CMD_NONE 4'h0
`define DTP_CMD_READ 4'h1
`define DTP_CMD_WR_RAM_W 4'h2
`define DTP_CMD_WR_RAM_D 4'h3
`define DTP_CMD_WR_EE_D 4'hd
`define DTP_CMD_WR_EE_W 4'he
`define DTP_CMD_TEXT 4'hf

// reply codes, slave to master
`define DTP_RPL_NONE 4'h0
`define DTP_RPL_WORD 4'h1
`define DTP_RPL_DWORD 4'h2
`define DTP_RPL_FAIL 4'h7

// error value for a command that cannot be executed
`define DTP_ERR_NO_PARAM 16'h0000
`define DTP_ERR_DATA_TYPE 16'h0005

// control word bit positions
`define DTP_CW_PRESET_LSB 0
`define DTP_CW_PRESET_MSB 1
`define DTP_CW_DC_BRAKE 2
`define DTP_CW_COAST 3
`define DTP_CW_QSTOP 4
`define DTP_CW_FREEZE 5
`define DTP_CW_START 6
`define DTP_CW_RESET 7
`define DTP_CW_JOG 8
`define DTP_CW_VALID 10
`define DTP_CW_RELAY1 11
`define DTP_CW_RELAY2 12
`define DTP_CW_SETUP_LSB 13
`define DTP_CW_SETUP_MSB 14

// parameter store reset value
`define DTP_PARAM_RESET 32'h0000_0000

`endif

//--- inc/dtp_pkg.sv
// types for the drive telegram parameter/process interpreter
// assumes dtp_defs.svh is on the include path
package dtp_pkg;
   `include "dtp_defs.svh"

   // one telegram's parameter and process blocks
   typedef struct packed {
      logic [15:0] parameter_key_word;
      logic [15:0] parameter_index_word;
      logic [31:0] parameter_value_field;
      logic [15:0] process_word_first;
      logic [15:0] process_word_second;
   } dtp_telegram_s;

   // decoded drive commands
   typedef struct packed {
      logic [1:0] preset_sel;
      logic dc_brake;
      logic coast_stop;
      logic quick_stop;
      logic freeze;
      logic ramp_stop;
      logic start;
      logic reset_pulse;
      logic jog;
      logic relay1;
      logic relay2;
      logic [1:0] setup_sel;
   } dtp_drive_cmd_s;

   typedef enum logic [1:0] {
      DTP_IDLE,
      DTP_LOOKUP,
      DTP_REPLY
   } dtp_state_e;
endpackage : dtp_pkg

//--- hw/dtp_ctrl_decode.sv
// control word decoder: turns a valid control word into drive commands
// assumes the word is presented with a one-cycle strobe per telegram
`timescale 1ns/1ns
`include "dtp_defs.svh"
module dtp_ctrl_decode (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // control word in
   input wire logic i_strobe,
   input wire logic [15:0] i_control_word,
   // decoded commands out
   output dtp_pkg::dtp_drive_cmd_s o_cmd
);
   import dtp_pkg::*;

   wire [15:0] cw = i_control_word;
   wire take = i_strobe & cw[`DTP_CW_VALID];
   logic reset_level;
   dtp_drive_cmd_s cmd;
   dtp_drive_cmd_s next_cmd;

   // decode; bit 09 has no effect and is never looked at
   always_comb begin
      next_cmd = cmd;
      next_cmd.reset_pulse = 1'b0;
      if (take) begin
         next_cmd.preset_sel = cw[`DTP_CW_PRESET_MSB:`DTP_CW_PRESET_LSB];
         next_cmd.dc_brake = ~cw[`DTP_CW_DC_BRAKE];
         next_cmd.coast_stop = ~cw[`DTP_CW_COAST];
         next_cmd.quick_stop = ~cw[`DTP_CW_QSTOP];
         next_cmd.freeze = ~cw[`DTP_CW_FREEZE];
         next_cmd.ramp_stop = ~cw[`DTP_CW_START];
         next_cmd.start = cw[`DTP_CW_START];
         // reset acts on the 0 to 1 change only
         next_cmd.reset_pulse = cw[`DTP_CW_RESET] & ~reset_level;
         next_cmd.jog = cw[`DTP_CW_JOG];
         next_cmd.relay1 = cw[`DTP_CW_RELAY1];
         next_cmd.relay2 = cw[`DTP_CW_RELAY2];
         next_cmd.setup_sel = cw[`DTP_CW_SETUP_MSB:`DTP_CW_SETUP_LSB];
      end
   end

   // safe state after reset: coast stop and ramp stop asserted, relays off
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         cmd <= '{preset_sel: 2'h0, dc_brake: 1'b0, coast_stop: 1'b1,
                  quick_stop: 1'b0, freeze: 1'b0, ramp_stop: 1'b1,
                  start: 1'b0, reset_pulse: 1'b0, jog: 1'b0,
                  relay1: 1'b0, relay2: 1'b0, setup_sel: 2'h0};
         reset_level <= 1'b0;
      end else begin
         cmd <= next_cmd;
         if (take) begin
            reset_level <= cw[`DTP_CW_RESET];
         end
      end
   end

   assign o_cmd = cmd;
endmodule : dtp_ctrl_decode

//--- hw/dtp_interp.sv
// drive telegram interpreter: parameter read/write and process block
// assumes one request telegram per i_req_valid pulse, fully parallel
`timescale 1ns/1ns
`include "dtp_defs.svh"
module dtp_interp #(
   parameter int NUM_PARAMS = 16
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // request telegram from the master
   input wire logic i_req_valid,
   input dtp_pkg::dtp_telegram_s i_req,
   // drive state to report
   input wire logic [15:0] i_status_word,
   input wire logic [15:0] i_output_freq,
   // reply telegram to the master
   output logic o_rsp_valid,
   output dtp_pkg::dtp_telegram_s o_rsp,
   // process outputs toward the drive
   output logic [15:0] o_reference,
   output dtp_pkg::dtp_drive_cmd_s o_cmd,
   // parameter write notifications
   output logic o_eeprom_save,
   output logic [10:0] o_save_number
);
   import dtp_pkg::*;

   localparam int IDX_W = $clog2(NUM_PARAMS);

   // ************************************************************
   // request decoding
   // ************************************************************
   dtp_state_e state;
   dtp_state_e next_state;
   dtp_telegram_s req;
   logic [31:0] store [NUM_PARAMS];

   wire [3:0] cmd_code = req.parameter_key_word[`DTP_CMD_MSB:`DTP_CMD_LSB];
   wire [10:0] pnum = req.parameter_key_word[`DTP_PNUM_MSB:`DTP_PNUM_LSB];
   wire in_range = pnum < 11'(NUM_PARAMS);
   // low bits index the store; in_range keeps larger numbers from aliasing
   wire [IDX_W-1:0] pidx = pnum[IDX_W-1:0];
   wire is_read = cmd_code == `DTP_CMD_READ;
   wire is_wr_w = cmd_code == `DTP_CMD_WR_RAM_W
                | cmd_code == `DTP_CMD_WR_EE_W;
   wire is_wr_d = cmd_code == `DTP_CMD_WR_RAM_D
                | cmd_code == `DTP_CMD_WR_EE_D;
   // eeprom variants are the master's choice for persistence
   wire is_ee = cmd_code == `DTP_CMD_WR_EE_W
              | cmd_code == `DTP_CMD_WR_EE_D;
   wire is_none = cmd_code == `DTP_CMD_NONE;
   // text transfer is not supported here and answers as a type error
   wire is_known = is_read | is_wr_w | is_wr_d | is_none;
   wire do_write = (is_wr_w | is_wr_d) & in_range;
   // word write fills the low word only; high word forced to zero
   wire [31:0] wr_value = is_wr_w ? {16'h0000, req.parameter_value_field[15:0]}
                                  : req.parameter_value_field;
   wire [31:0] rd_value = store[pidx];

   // ************************************************************
   // reply assembly
   // ************************************************************
   wire [3:0] rpl_code = is_none ? `DTP_RPL_NONE
                       : (!is_known || !in_range) ? `DTP_RPL_FAIL
                       : is_wr_d ? `DTP_RPL_DWORD
                       : `DTP_RPL_WORD;
   // error value: data type mismatch for text and other unknown codes, missing number otherwise
   wire [15:0] err_val = !is_known ? `DTP_ERR_DATA_TYPE : `DTP_ERR_NO_PARAM;
   // read places the present value, low word carries narrow values
   wire [31:0] rsp_value = (rpl_code == `DTP_RPL_FAIL) ? {16'h0000, err_val}
                         : is_read ? rd_value
                         : is_none ? 32'h0000_0000
                         : wr_value;
   // keep the request's parameter number in the reply key
   wire [15:0] rsp_key = {rpl_code, req.parameter_key_word[11:0]};
   dtp_telegram_s next_rsp;
   assign next_rsp.parameter_key_word = rsp_key;
   assign next_rsp.parameter_index_word = req.parameter_index_word;
   assign next_rsp.parameter_value_field = rsp_value;
   // status first, output frequency second
   assign next_rsp.process_word_first = i_status_word;
   assign next_rsp.process_word_second = i_output_freq;

   // ************************************************************
   // sequencing
   // ************************************************************
   // next state: a request taken in idle is always answered
   always_comb begin
      next_state = state;
      case (state)
         DTP_IDLE: begin
            if (i_req_valid) begin
               next_state = DTP_LOOKUP;
            end
         end
         DTP_LOOKUP: begin
            next_state = DTP_REPLY;
         end
         DTP_REPLY: begin
            next_state = DTP_IDLE;
         end
         default: begin
            next_state = DTP_IDLE;
         end
      endcase
   end

   // phase strobes shared by capture, store and reply logic; as named
   // wires they keep every clocked block down to one register
   wire take = state == DTP_IDLE && i_req_valid;
   wire in_lookup = state == DTP_LOOKUP;
   wire in_reply = state == DTP_REPLY;

   // phase register; requests arriving outside idle are dropped without
   // any sign, so the master has to keep three cycles between requests
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= DTP_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // request copy, so the master may change its lines right after a take
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         req <= '0;
      end else if (take) begin
         req <= i_req;
      end
   end

   // parameter store, one 32-bit value per parameter, flip-flops; values are kept
   // as the transferred integers, scaling by conversion index is left to
   // the master
   genvar g;
   generate
      for (g = 0; g < NUM_PARAMS; g++) begin : g_store
         always_ff @(posedge i_clock or negedge i_resetn) begin
            if (!i_resetn) begin
               store[g] <= `DTP_PARAM_RESET;
            end else if (in_lookup && do_write && pidx == IDX_W'(g)) begin
               store[g] <= wr_value;
            end
         end
      end
   endgenerate

   // reply strobe: one cycle, the cycle after the reply phase; a master
   // that misses it still finds the telegram held in o_rsp
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rsp_valid <= 1'b0;
      end else begin
         o_rsp_valid <= in_reply;
      end
   end

   // reply telegram holds until the next reply, so a slow reader is safe
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rsp <= '0;
      end else if (in_reply) begin
         o_rsp <= next_rsp;
      end
   end

   // save notice: one pulse per in-range write that asked for eeprom
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_eeprom_save <= 1'b0;
      end else begin
         o_eeprom_save <= in_lookup && do_write && is_ee;
      end
   end

   // number of the last request looked up, valid alongside the save pulse
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_save_number <= 11'h000;
      end else if (in_lookup) begin
         o_save_number <= pnum;
      end
   end

   // reference taken with the request, beside its control word
   // it is not gated by the valid bit, which covers the control word only
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reference <= 16'h0000;
      end else if (take) begin
         o_reference <= i_req.process_word_second;
      end
   end

   // control word is only ever consumed from the request
   dtp_ctrl_decode u_decode (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_strobe(take),
      .i_control_word(i_req.process_word_first),
      .o_cmd(o_cmd)
   );
endmodule : dtp_interp

//--- verification/dtp_interp_monitor.sv
// checker on the telegram interpreter ports
// assumes requests at least three cycles apart
`timescale 1ns/1ns
module dtp_interp_monitor import dtp_pkg::*; #(
   parameter int NUM_PARAMS = 16
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // watched ports
   input wire logic i_req_valid,
   input dtp_pkg::dtp_telegram_s i_req,
   input wire logic o_rsp_valid,
   input dtp_pkg::dtp_telegram_s o_rsp,
   input wire logic [15:0] o_reference,
   input dtp_pkg::dtp_drive_cmd_s o_cmd
);
   // ****
   // properties
   // ****
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   // control word and its valid gate
   wire logic [15:0] cw = i_req.process_word_first;
   wire logic go = i_req_valid & cw[10];
   sequence s_take;
      i_req_valid ##3 o_rsp_valid;
   endsequence
   AST_RSP_LAT: assert property (i_req_valid |-> s_take)
      else $error("late reply");
   AST_RSP_ONE: assert property (o_rsp_valid |=> !o_rsp_valid)
      else $error("long reply strobe");
   AST_KEY_ECHO: assert property (s_take |->
      o_rsp.parameter_key_word[10:0] ==
      $past(i_req.parameter_key_word[10:0], 3))
      else $error("key not echoed");
   AST_GATE: assert property (i_req_valid && !cw[10] |=>
      $stable(o_cmd[13:6]) && $stable(o_cmd[4:0]) && !o_cmd.reset_pulse)
      else $error("invalid word acted on");
   AST_STOPS: assert property (go |=> o_cmd[11:6] ==
      $past({~cw[2], ~cw[3], ~cw[4], ~cw[5], ~cw[6], cw[6]}))
      else $error("stop bits wrong");
   AST_AUX: assert property (go |=>
      o_cmd[4:2] == $past({cw[8], cw[11], cw[12]}))
      else $error("jog or relay wrong");
   AST_SEL: assert property (go |=>
      {o_cmd[13:12], o_cmd[1:0]} == $past({cw[1:0], cw[14:13]}))
      else $error("selection wrong");
   AST_RST: assert property (o_cmd.reset_pulse |->
      $past(go && cw[7]) ##1 !o_cmd.reset_pulse)
      else $error("bad reset pulse");
   AST_REF: assert property (i_req_valid |=>
      o_reference == $past(i_req.process_word_second))
      else $error("reference wrong");
endmodule : dtp_interp_monitor
bind dtp_interp dtp_interp_monitor #(.NUM_PARAMS(NUM_PARAMS)) u_mon (
   .i_clock(i_clock), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
   .i_req(i_req), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp),
   .o_reference(o_reference), .o_cmd(o_cmd));

//--- verification/dtp_master_model.sv
// bus master model: sends request telegrams, collects replies
// assumes the slave answers within eight cycles
`timescale 1ns/1ns
module dtp_master_model import dtp_pkg::*; (
   // clock and reply
   input wire logic i_clock,
   input wire logic i_rsp_valid,
   input dtp_pkg::dtp_telegram_s i_rsp,
   // request toward the slave
   output logic o_req_valid,
   output dtp_pkg::dtp_telegram_s o_req
);
   // ****
   // transfer
   // ****
   initial begin
      o_req_valid = 1'b0;
      o_req = '0;
   end
   // one pulse, then replies are sampled at falling edges
   task automatic transact(input logic [15:0] key, input logic [31:0] val,
         input logic [15:0] cw, input logic [15:0] refv, input int gap,
         output dtp_telegram_s rsp);
      int n;
      repeat (gap) @(negedge i_clock);
      @(negedge i_clock);
      o_req = {key, 16'h0000, val, cw, refv};
      o_req_valid = 1'b1;
      @(negedge i_clock);
      o_req_valid = 1'b0;
      o_req = ~o_req; // released lines must not look held
      n = 0;
      while (i_rsp_valid !== 1'b1 && n < 8) begin
         @(negedge i_clock);
         n++;
      end
      rsp = (i_rsp_valid === 1'b1) ? i_rsp : 'x;
   endtask : transact
endmodule : dtp_master_model

//--- verification/testbench.sv
// self-checking bench for the telegram interpreter
// assumes master model and bound checker are compiled first
`timescale 1ns/1ns
module testbench;
   import dtp_pkg::*;
   // ****
   // harness
   // ****
   logic i_clock;
   logic i_resetn;
   logic req_valid;
   logic rsp_valid;
   logic eeprom_save;
   logic [15:0] status;
   logic [15:0] freq;
   logic [15:0] reference;
   logic [10:0] save_number;
   dtp_telegram_s req;
   dtp_telegram_s rsp_bus;
   dtp_telegram_s rsp;
   dtp_drive_cmd_s cmd;
   int mismatches = 0;
   int num_checks = 0;
   int saves = 0;
   int resets = 0;
   dtp_interp dut (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_req_valid(req_valid),
      .i_req(req), .i_status_word(status), .i_output_freq(freq),
      .o_rsp_valid(rsp_valid), .o_rsp(rsp_bus), .o_reference(reference),
      .o_cmd(cmd), .o_eeprom_save(eeprom_save), .o_save_number(save_number)
   );
   dtp_master_model m (
      .i_clock(i_clock), .i_rsp_valid(rsp_valid), .i_rsp(rsp_bus),
      .o_req_valid(req_valid), .o_req(req)
   );
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   // one-cycle pulses counted once each, mid-cycle where they are settled
   always @(negedge i_clock) begin
      if (eeprom_save === 1'b1)
         saves++;
      if (cmd.reset_pulse === 1'b1)
         resets++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // expected commands; the reset strobe is gone by compare time
   function automatic dtp_drive_cmd_s decode(input logic [15:0] w);
      return dtp_drive_cmd_s'({w[1:0], ~w[2], ~w[3], ~w[4], ~w[5],
         ~w[6], w[6], 1'b0, w[8], w[11], w[12], w[14:13]});
   endfunction : decode
   // parameter access with an invalid control word
   task automatic par(input logic [15:0] key, input logic [31:0] val,
         input logic [15:0] rkey, input logic [31:0] rval);
      m.transact(key, val, 16'h0000, 16'h0000, 0, rsp);
      check(rsp.parameter_key_word, rkey);
      check(rsp.parameter_value_field, rval);
      check({rsp.process_word_first, rsp.process_word_second},
         {status, freq});
   endtask : par
   // control word with no parameter command
   task automatic ctl(input logic [15:0] w, input logic [15:0] ew);
      m.transact(16'h0000, 32'h0, w, ~w, 2, rsp);
      check(cmd, decode(ew));
      check(reference, {16'h0000, ~w});
   endtask : ctl
   // ****
   // tests
   // ****
   initial begin
      i_resetn = 1'b0;
      status = 16'h0a5c;
      freq = 16'h3c81;
      repeat (2) @(negedge i_clock);
      i_resetn = 1'b1;
      check(cmd, 14'h0480);
      check(reference, 0);
      par(16'h1006, 32'h0, 16'h1006, 32'h0);
      par(16'he00f, 32'h0000_0014, 16'h100f, 32'h14);
      check(save_number, 11'h00f);
      par(16'h100f, 32'h0, 16'h100f, 32'h14);
      par(16'h3003, 32'h0001_86a0, 16'h2003, 32'h0001_86a0);
      par(16'h1003, 32'h0, 16'h1003, 32'h0001_86a0);
      par(16'h2002, 32'hffff_03e8, 16'h1002, 32'h03e8);
      par(16'hd001, 32'h8000_0001, 16'h2001, 32'h8000_0001);
      par(16'h1010, 32'h0, 16'h7010, 32'h0);
      par(16'hf001, 32'h0, 16'h7001, 32'h5);
      check(saves, 2);
      ctl(16'h0400, 16'h0400);
      ctl(16'h5d9e, 16'h5d9e);
      ctl(16'h0000, 16'h5d9e);
      ctl(16'h7fff, 16'h7fff);
      ctl(16'h3e69, 16'h3e69);
      ctl(16'h5d9e, 16'h5d9e);
      check(resets, 2);
      print_verdict();
   end
   initial begin
      #6000;
      mismatches++;
      print_verdict();
   end
endmodule : testbench
